// File: rtl/sdm_pkg.sv
// Shared constants for the sigma delta modulator and sinc3 decimator.
// Assumes a single 200 MHz system clock; one modulator sample per sample strobe.
//
// Contract
// - Difference is input minus previous feedback, integrated.
// - Positive sum gives bit 1; feedback plus/minus one.
// - Input three eighths repeats every sixteen samples.
// - Feedback average tracks the applied input.
// - Back-end filter is recursive (integrators, then combs) with built-in decimation.
// - One filtered word per decimation period emitted.
// - Third-order sinc comb from integrators and combs.
// - Decimation ratio accepted from 10 through 2000.
// - Ratio places first notch between 10Hz and 2kHz.
package sdm_pkg;

    // ************************************************************
    // Input sample format
    // ************************************************************
    // Input is signed fixed point: ONE_LSB counts represent +1.0.
    localparam int IN_WIDTH  = 16;
    localparam int FRAC_BITS = 12;

    // ************************************************************
    // Decimation limits and widths
    // ************************************************************
    localparam int RATIO_MIN   = 10;
    localparam int RATIO_MAX   = 2000;
    localparam int RATIO_WIDTH = 11;
    // Sinc3 growth is 3*log2(2000) < 33 bits; one sign bit plus margin.
    localparam int CIC_ORDER   = 3;
    localparam int ACC_WIDTH   = 36;
    // Output word holds the full comb result.
    localparam int OUT_WIDTH   = ACC_WIDTH;

    // ************************************************************
    // Reset values and FIFO depth
    // ************************************************************
    localparam logic [RATIO_WIDTH-1:0] RATIO_RESET = 11'h040;
    localparam int FIFO_DEPTH = 4;

endpackage

// File: rtl/sigma_delta_mod_decimator.sv
// First-order sigma delta modulator loop feeding a sinc3 decimator and FIFO.
// Assumes the sample source and word consumer share sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sigma_delta_mod_decimator
    import sdm_pkg::*;
#(
    parameter int IW = IN_WIDTH,
    parameter int FB = FRAC_BITS,
    parameter int RW = RATIO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 sample_valid,
    output logic                      sample_ready,
    input  wire logic signed [IW-1:0] sample_in,
    input  wire logic        [RW-1:0] dec_ratio,
    output logic                      mod_bit,
    output logic signed [1:0]         mod_feedback,
    output logic                      ratio_error,
    output logic                      word_valid,
    input  wire logic                 word_ready,
    output logic        [OUT_WIDTH-1:0] word_data
);
    // ************************************************************
    // Parameter checks
    // ************************************************************
    initial begin
        if (FB >= IW - 2) $error("Input needs headroom above +/-1 for the loop sum.");
        if (RW < 11) $error("Ratio width must hold 2000.");
    end

    localparam logic signed [IW+1:0] ONE_LSB = (IW+2)'(1) << FB;

    // ************************************************************
    // Modulator loop state
    // ************************************************************
    logic signed [IW+1:0] integ_sum;       // Integrator sum.
    logic signed [IW+1:0] next_integ_sum;
    logic signed [1:0]    next_feedback;   // -1, 0 (reset), or +1.
    logic                 next_mod_bit;
    logic signed [IW+1:0] loop_diff;       // Input minus last feedback.
    logic signed [IW+1:0] fb_scaled;
    logic                 ratio_ok;        // Ratio inside 10..2000.
    logic [RW-1:0]        ratio_held;      // Ratio used by the filter.
    logic [RW-1:0]        next_ratio_held;
    logic                 step;            // A sample is taken this cycle.
    logic                 fifo_ready;
    logic                 dec_valid;
    logic [OUT_WIDTH-1:0] dec_word;

    // The loop stalls while the FIFO is full, so back-pressure reaches the source.
    assign sample_ready = fifo_ready;
    assign step         = sample_valid && fifo_ready;

    // Out-of-range settings are refused; the last good ratio stays in use.
    assign ratio_ok    = (dec_ratio >= RW'(RATIO_MIN)) && (dec_ratio <= RW'(RATIO_MAX));
    assign ratio_error = !ratio_ok;

    // Feedback in input scale: +1 and -1 map to plus or minus ONE_LSB.
    always_comb begin
        case (mod_feedback)
            2'sb01:  fb_scaled = ONE_LSB;
            2'sb11:  fb_scaled = -ONE_LSB;
            default: fb_scaled = '0;
        endcase
    end

    // Difference, integration and one-bit quantisation.
    always_comb begin
        loop_diff       = (IW+2)'(sample_in) - fb_scaled;
        next_integ_sum  = integ_sum;
        next_mod_bit    = mod_bit;
        next_feedback   = mod_feedback;
        next_ratio_held = ratio_ok ? dec_ratio : ratio_held;
        if (step) begin
            next_integ_sum = integ_sum + loop_diff;
            // Zero or negative sums give 0, so an input of 3/8 settles to a period-16 pattern.
            // The stored sum is tested, so the bit always agrees with the wrapped integrator.
            next_mod_bit   = next_integ_sum > (IW+2)'(0);
            next_feedback  = next_mod_bit ? 2'sb01 : 2'sb11;
        end
    end

    // Register the loop state; the first sample sees zero feedback.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            integ_sum    <= '0;
            mod_bit      <= 1'b0;
            mod_feedback <= 2'sb00;
            ratio_held   <= RATIO_RESET;
        end else begin
            integ_sum    <= next_integ_sum;
            mod_bit      <= next_mod_bit;
            mod_feedback <= next_feedback;
            ratio_held   <= next_ratio_held;
        end
    end

    // ************************************************************
    // Decimation filter
    // ************************************************************
    // Notch sits at sample rate / ratio; 10..2000 covers 10Hz..2kHz for the chosen rate.
    sinc3_decimator #(
        .AW (OUT_WIDTH),
        .RW (RW)
    ) u_dec (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .bit_valid  (step),
        .bit_in     (next_mod_bit),
        .ratio      (ratio_held),
        .word_valid (dec_valid),
        .word       (dec_word)
    );

    // ************************************************************
    // Output buffering
    // ************************************************************
    // A word arrives at most once per ten steps, and steps need a free slot, so none is lost.
    word_fifo #(
        .WIDTH (OUT_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (dec_valid),
        .in_ready  (fifo_ready),
        .in_data   (dec_word),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );
endmodule
`default_nettype wire

// File: rtl/sinc3_decimator.sv
// Third-order cascaded integrator-comb decimator on a one-bit stream.
// Assumes bit_valid strobes once per modulator sample on the system clock.
`timescale 1ns/1ps
`default_nettype none
module sinc3_decimator
    import sdm_pkg::*;
#(
    parameter int AW = ACC_WIDTH,
    parameter int RW = RATIO_WIDTH
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    input  wire logic          bit_valid,
    input  wire logic          bit_in,
    input  wire logic [RW-1:0] ratio,
    output logic               word_valid,
    output logic      [AW-1:0] word
);
    // ************************************************************
    // Integrator and comb state
    // ************************************************************
    initial begin
        if (AW < 34) $error("sinc3_decimator AW too narrow for ratio 2000.");
    end

    logic [AW-1:0] integ [CIC_ORDER];      // Integrator chain.
    logic [AW-1:0] comb_dly [CIC_ORDER];   // Comb delay elements.
    logic [AW-1:0] next_integ [CIC_ORDER];
    logic [AW-1:0] next_comb_dly [CIC_ORDER];
    logic [AW-1:0] stage [CIC_ORDER+1];    // Comb stage inputs and output.
    logic [RW-1:0] phase;                  // Position within one period.
    logic [RW-1:0] next_phase;
    logic          dump;                   // Last sample of the period.
    logic          next_word_valid;
    logic [AW-1:0] next_word;

    // Bit 1 weighs +1, bit 0 weighs -1, as the modulator feedback does.
    assign dump = bit_valid && (phase >= ratio - RW'(1));

    // Integrators, comb subtractions and period counter.
    always_comb begin
        next_phase = phase;
        if (bit_valid) begin
            next_phase = dump ? '0 : phase + RW'(1);
        end
        stage[0] = integ[CIC_ORDER-1];
        for (int k = 0; k < CIC_ORDER; k++) begin
            next_integ[k]    = integ[k];
            next_comb_dly[k] = comb_dly[k];
            stage[k+1]       = stage[k] - comb_dly[k];
            if (bit_valid) begin
                // Wraparound sums; the comb differences recover the true value.
                // The index is clamped so stage 0 never names a stage below the chain.
                if (k == 0) begin
                    next_integ[k] = integ[k] + (bit_in ? AW'(1) : {AW{1'b1}});
                end else begin
                    next_integ[k] = integ[k] + integ[(k > 0) ? k - 1 : 0];
                end
            end
            if (dump) begin
                next_comb_dly[k] = stage[k];
            end
        end
        next_word_valid = dump;
        next_word       = dump ? stage[CIC_ORDER] : word;
    end

    // Register all filter state.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < CIC_ORDER; k++) begin
                integ[k]    <= '0;
                comb_dly[k] <= '0;
            end
            phase      <= '0;
            word_valid <= 1'b0;
            word       <= '0;
        end else begin
            integ      <= next_integ;
            comb_dly   <= next_comb_dly;
            phase      <= next_phase;
            word_valid <= next_word_valid;
            word       <= next_word;
        end
    end
endmodule
`default_nettype wire

// File: rtl/word_fifo.sv
// A small synchronous FIFO for decimated words.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // ************************************************************
    // Storage and pointers
    // ************************************************************
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // Full count needs AW+1 bits; casting to AW bits first would wrap DEPTH to zero.
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("word_fifo DEPTH must be a power of two >= 2.");
    end

    logic [WIDTH-1:0] mem [DEPTH];   // Word storage.
    logic [AW-1:0]    rd_ptr;        // Read index.
    logic [AW-1:0]    wr_ptr;        // Write index.
    logic [AW:0]      count;         // Words held.
    logic [AW-1:0]    next_rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // Honest flags straight from the count.
    assign in_ready  = (count != DEPTH_C);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Next pointer and count values.
    always_comb begin
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    // Register pointers and count.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
    end

    // Storage needs no reset; only written entries are ever read.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

// File: tb/sdm_assertions.sv
// Port checker for the modulator and decimator top.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sdm_checker
    import sdm_pkg::*;
#(
    parameter int IW = IN_WIDTH,
    parameter int RW = RATIO_WIDTH
) (
    input wire logic                 sys_clk,
    input wire logic                 rst_b,
    input wire logic                 sample_valid,
    input wire logic                 sample_ready,
    input wire logic signed [IW-1:0] sample_in,
    input wire logic        [RW-1:0] dec_ratio,
    input wire logic                 mod_bit,
    input wire logic signed [1:0]    mod_feedback,
    input wire logic                 ratio_error,
    input wire logic                 word_valid,
    input wire logic                 word_ready,
    input wire logic [OUT_WIDTH-1:0] word_data
);
    // ****************************************
    // Properties, all on the system clock.
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_fb_map; mod_feedback != 2'sb00 |-> mod_feedback == (mod_bit ? 2'sb01 : 2'sb11); endproperty
    a_fb_map: assert property (p_fb_map) else $error("feedback disagrees with bit");
    property p_zero; mod_feedback == 2'sb00 |-> !mod_bit; endproperty
    a_zero: assert property (p_zero) else $error("bit set before first sample");
    property p_ratio; ratio_error == (dec_ratio < RATIO_MIN || dec_ratio > RATIO_MAX); endproperty
    a_ratio: assert property (p_ratio) else $error("ratio range flag wrong");
    // The loop state may only move when a sample is really taken.
    property p_hold; !(sample_valid && sample_ready) |=> $stable(mod_bit) && $stable(mod_feedback); endproperty
    a_hold: assert property (p_hold) else $error("loop moved without sample");
    property p_word_hold; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
    a_word_hold: assert property (p_word_hold) else $error("word dropped while stalled");
    property p_full; !sample_ready |-> word_valid; endproperty
    a_full: assert property (p_full) else $error("refused with no word waiting");
    property p_rst; $rose(rst_b) |-> mod_feedback == 2'sb00 && !word_valid && sample_ready; endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
    property p_first; sample_valid && sample_ready && mod_feedback == 2'sb00 |=> mod_bit == ($past(sample_in) > 0); endproperty
    a_first: assert property (p_first) else $error("first quantizer bit wrong");
endmodule
bind sigma_delta_mod_decimator sdm_checker #(.IW(IW), .RW(RW)) chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_in(sample_in), .dec_ratio(dec_ratio),
    .mod_bit(mod_bit), .mod_feedback(mod_feedback), .ratio_error(ratio_error), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data));
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the modulator and sinc3 decimator.
// Assumes constant inputs whose bit pattern period divides the ratio.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdm_pkg::*;
    typedef struct { logic [IN_WIDTH-1:0] din; logic [RATIO_WIDTH-1:0] ratio; logic stall; logic [OUT_WIDTH-1:0] exp; } row_s;
    logic                       sys_clk = 1'b0;
    logic                       rst_b = 1'b0;
    logic                       sample_valid = 1'b0;
    logic signed [IN_WIDTH-1:0] sample_in = 16'h0000;
    logic [RATIO_WIDTH-1:0]     dec_ratio = 11'h010;
    logic                       stall = 1'b0;
    logic                       sample_ready, mod_bit, ratio_error, word_valid, word_ready;
    logic signed [1:0]          mod_feedback;
    logic [OUT_WIDTH-1:0]       word_data;
    logic                       take_q = 1'b0;
    logic                       saw_full = 1'b0;
    logic [OUT_WIDTH-1:0]       words[$];
    logic                       bits[$];
    int                         fails = 0, num_checks = 0, cycles = 0, ntake = 0;
    // Quantizer bits of samples 1..18 for a steady input of three eighths.
    localparam logic [17:0] TBL = 18'h2DBB6;
    // Steady words equal ratio cubed times the input.
    row_s rows[5] = '{'{16'h0600, 11'h010, 1'b0, 36'h000000600}, '{16'h0600, 11'h020, 1'b0, 36'h000003000},
                      '{16'h0000, 11'h010, 1'b0, 36'h000000000}, '{16'hF800, 11'h010, 1'b0, 36'hFFFFFF800},
                      '{16'h1000, 11'h00A, 1'b1, 36'h0000003E8}};
    logic [RATIO_WIDTH-1:0] edge_ratio[4] = '{11'h009, 11'h00A, 11'h7D0, 11'h7D1};

    always #2.5 sys_clk = ~sys_clk;

    sigma_delta_mod_decimator dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_in(sample_in), .dec_ratio(dec_ratio), .mod_bit(mod_bit),
        .mod_feedback(mod_feedback), .ratio_error(ratio_error), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data));
    word_consumer consumer_u (.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall), .word_ready(word_ready));

    // ****************************************
    // Monitor: records bits, words and sample count; cuts a hang short.
    // ****************************************
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        take_q <= sample_valid && sample_ready && rst_b;
        if (!rst_b) begin
            words.delete();
            bits.delete();
            ntake <= 0;
        end else begin
            if (take_q) bits.push_back(mod_bit);
            if (sample_valid && sample_ready) ntake <= ntake + 1;
            if (word_valid && word_ready) words.push_back(word_data);
            if (!sample_ready) saw_full <= 1'b1;
        end
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end

    task check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Each row starts from a fresh reset, so a reset in mid-run is exercised too.
    task run_row(input row_s r);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        sample_valid <= 1'b0;
        stall <= r.stall;
        sample_in <= r.din;
        dec_ratio <= r.ratio;
        repeat (4) @(posedge sys_clk);
        check(sample_ready, 1'b1);
        check(word_valid, 1'b0);
        check(mod_feedback, 2'b00);
        rst_b <= 1'b1;
        sample_valid <= 1'b1;
        repeat (r.stall ? 60 : 0) @(posedge sys_clk);
        stall <= 1'b0;
        repeat (8 * r.ratio) @(posedge sys_clk);
        sample_valid <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check(words.size(), ntake / r.ratio);
        // Word k spans samples from (k-2)*ratio on, after the three-sample integrator pipeline,
        // so word 2 still holds the empty slot before the first sample; word 3 is the first steady one.
        for (int i = 3; i < words.size(); i++) check(words[i], r.exp);
        if (r.din == 16'h0600) begin
            for (int i = 0; i < 18; i++) check(bits[i], TBL[17-i]);
        end
    endtask

    initial begin
        foreach (rows[i]) run_row(rows[i]);
        check(saw_full, 1'b1);
        foreach (edge_ratio[i]) begin
            dec_ratio <= edge_ratio[i];
            @(posedge sys_clk);
            @(posedge sys_clk);
            check(ratio_error, edge_ratio[i] < RATIO_MIN || edge_ratio[i] > RATIO_MAX);
        end
        stop_test();
    end
endmodule
`default_nettype wire

// File: tb/word_consumer.sv
// Consumer of decimated words that can stall on command.
// Assumes the bench raises stall to fill the word buffer.
`timescale 1ns/1ps
`default_nettype none
module word_consumer (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic stall,
    output logic     word_ready
);
    // Ready is registered, so a stall lands one cycle late, as a real sink would.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            word_ready <= 1'b0;
        end else begin
            word_ready <= !stall;
        end
    end
endmodule
`default_nettype wire
